// ### rtl/sscr_top.sv
// serial port status flags and serial clock rate select
// assumes the shift engine supplies busy, done and data-write strobes on the system clock
//
// Our own choice: the address-and-strobe port.
module sscr_top (
	input wire logic CLK_I,
	input wire logic RST_I,
	input wire logic CE_I,
	input wire logic [7:0] ADDR_I,
	input wire logic [7:0] WDATA_I,
	input wire logic WR_I,
	input wire logic RD_I,
	output logic [7:0] RDATA_O,
	input wire logic SHIFT_BUSY_I,
	input wire logic XFER_DONE_I,
	input wire logic DATA_WR_I,
	input wire logic INT_VEC_ACK_I,
	input wire logic MASTER_I,
	input wire logic SS_N_I,
	input wire logic PEER_SCK_I,
	output logic SCK_O,
	output logic SCK_OE_O,
	output logic SHIFT_TICK_O,
	output logic SELECT_PIN_DISABLE_O,
	output logic LSB_FIRST_O,
	output logic IRQ_O
);

	////////////////////////////////////////////////////////////////////////////////
	// state
	logic [1:0] rate_ff;
	logic sel_dis_ff;
	logic lsbf_ff;
	logic done_ff;
	logic coll_ff;
	logic modf_ff;
	logic [sscr_pkg::EVT_W-1:0] int_stat_ff;
	logic [sscr_pkg::EVT_W-1:0] int_mask_ff;
	logic irq_ff;
	logic [7:0] rdata_ff;
	logic sck_oe_ff;
	logic peer_sck_ff;
	logic tick_ff;
	logic div_sck;
	logic div_rise;

	sscr_pkg::sscr_bus_type bus;
	sscr_pkg::sscr_status_type status_view;

	assign bus.addr = ADDR_I;
	assign bus.wdata = WDATA_I;
	assign bus.wr = WR_I;
	assign bus.rd = RD_I;

	////////////////////////////////////////////////////////////////////////////////
	// address decode
	wire wr_status = bus.wr && (bus.addr == sscr_pkg::ADDR_STATUS);
	wire wr_int_stat = bus.wr && (bus.addr == sscr_pkg::ADDR_INT_STAT);
	wire wr_int_mask = bus.wr && (bus.addr == sscr_pkg::ADDR_INT_MASK);
	wire rd_status = bus.rd && (bus.addr == sscr_pkg::ADDR_STATUS);
	wire rd_int_stat = bus.rd && (bus.addr == sscr_pkg::ADDR_INT_STAT);
	wire rd_int_mask = bus.rd && (bus.addr == sscr_pkg::ADDR_INT_MASK);

	////////////////////////////////////////////////////////////////////////////////
	// flag events; in each flag a set beats a clear arriving in the same cycle
	wire done_set = XFER_DONE_I;
	wire done_clr = INT_VEC_ACK_I || (wr_status && !bus.wdata[sscr_pkg::BIT_DONE]);
	wire coll_set = DATA_WR_I && SHIFT_BUSY_I;
	wire coll_clr = (DATA_WR_I && !SHIFT_BUSY_I) || (wr_status && !bus.wdata[sscr_pkg::BIT_COLL]);
	wire modf_set = MASTER_I && !sel_dis_ff && !SS_N_I;
	wire modf_clr = wr_status && !bus.wdata[sscr_pkg::BIT_MODF];

	wire nxt_done = done_set || (done_ff && !done_clr);
	wire nxt_coll = coll_set || (coll_ff && !coll_clr);
	wire nxt_modf = modf_set || (modf_ff && !modf_clr);

	// writing a one to a flag bit leaves it alone; only zero clears
	wire [1:0] nxt_rate = wr_status ? bus.wdata[1:0] : rate_ff;
	wire nxt_sel_dis = wr_status ? bus.wdata[sscr_pkg::BIT_SEL_DIS] : sel_dis_ff;
	wire nxt_lsbf = wr_status ? bus.wdata[sscr_pkg::BIT_LSBF] : lsbf_ff;

	////////////////////////////////////////////////////////////////////////////////
	// interrupt status: sticky, write one to clear, set wins
	wire [sscr_pkg::EVT_W-1:0] evt_vec = {modf_set, coll_set, done_set};
	wire [sscr_pkg::EVT_W-1:0] int_clr = wr_int_stat ? bus.wdata[sscr_pkg::EVT_W-1:0] : '0;
	wire [sscr_pkg::EVT_W-1:0] nxt_int_stat = evt_vec | (int_stat_ff & ~int_clr);
	wire [sscr_pkg::EVT_W-1:0] nxt_int_mask = wr_int_mask ? bus.wdata[sscr_pkg::EVT_W-1:0] : int_mask_ff;
	wire nxt_irq = |(nxt_int_stat & nxt_int_mask);

	////////////////////////////////////////////////////////////////////////////////
	// read mux; data stand only in the cycle after the strobe, unmapped reads zero
	assign status_view.done = done_ff;
	assign status_view.coll = coll_ff;
	assign status_view.modf = modf_ff;
	assign status_view.busy = SHIFT_BUSY_I;
	assign status_view.sel_dis = sel_dis_ff;
	assign status_view.lsbf = lsbf_ff;
	assign status_view.rate = rate_ff;

	wire [7:0] int_stat_rd = {{(8-sscr_pkg::EVT_W){1'b0}}, int_stat_ff};
	wire [7:0] int_mask_rd = {{(8-sscr_pkg::EVT_W){1'b0}}, int_mask_ff};
	wire [7:0] nxt_rdata = rd_status ? status_view :
		rd_int_stat ? int_stat_rd :
		rd_int_mask ? int_mask_rd : sscr_pkg::RDATA_RST;

	////////////////////////////////////////////////////////////////////////////////
	// serial clock: divider drives the pin in master mode only
	sscr_clk_div #(
		.CNT_W(sscr_pkg::DIV_CNT_W)
	) i_sscr_clk_div (
		.clk_i(CLK_I),
		.rst_i(RST_I),
		.ce_i(CE_I),
		.en_i(MASTER_I),
		.rate_i(rate_ff),
		.sck_o(div_sck),
		.rise_o(div_rise)
	);

	// peer clock is taken as synchronous; its rising edge times the shifter as slave
	wire peer_rise = PEER_SCK_I && !peer_sck_ff;
	wire nxt_tick = MASTER_I ? div_rise : peer_rise;

	////////////////////////////////////////////////////////////////////////////////
	always_ff @(posedge CLK_I or posedge RST_I) begin
		if (RST_I) begin
			rate_ff <= sscr_pkg::RATE_RST;
			sel_dis_ff <= 1'b0;
			lsbf_ff <= 1'b0;
			done_ff <= 1'b0;
			coll_ff <= 1'b0;
			modf_ff <= 1'b0;
		end else if (CE_I) begin
			rate_ff <= nxt_rate;
			sel_dis_ff <= nxt_sel_dis;
			lsbf_ff <= nxt_lsbf;
			done_ff <= nxt_done;
			coll_ff <= nxt_coll;
			modf_ff <= nxt_modf;
		end
	end

	always_ff @(posedge CLK_I or posedge RST_I) begin
		if (RST_I) begin
			int_stat_ff <= '0;
			int_mask_ff <= sscr_pkg::INT_MASK_RST;
			irq_ff <= 1'b0;
			rdata_ff <= sscr_pkg::RDATA_RST;
		end else if (CE_I) begin
			int_stat_ff <= nxt_int_stat;
			int_mask_ff <= nxt_int_mask;
			irq_ff <= nxt_irq;
			rdata_ff <= nxt_rdata;
		end
	end

	always_ff @(posedge CLK_I or posedge RST_I) begin
		if (RST_I) begin
			sck_oe_ff <= 1'b0;
			peer_sck_ff <= 1'b0;
			tick_ff <= 1'b0;
		end else if (CE_I) begin
			sck_oe_ff <= MASTER_I;
			peer_sck_ff <= PEER_SCK_I;
			tick_ff <= nxt_tick;
		end
	end

	assign RDATA_O = rdata_ff;
	assign SCK_O = div_sck;
	assign SCK_OE_O = sck_oe_ff;
	assign SHIFT_TICK_O = tick_ff;
	assign SELECT_PIN_DISABLE_O = sel_dis_ff;
	assign LSB_FIRST_O = lsbf_ff;
	assign IRQ_O = irq_ff;

	////////////////////////////////////////////////////////////////////////////////
	default clocking cb @(posedge CLK_I); endclocking
	default disable iff (RST_I);

	a_done_set: assert property (
		CE_I && XFER_DONE_I |=> done_ff
	) else $error("transfer done did not set flag");

	a_done_vector_clr: assert property (
		CE_I && INT_VEC_ACK_I && !XFER_DONE_I |=> !done_ff
	) else $error("vector acknowledge did not clear done flag");

	a_done_sw_clr: assert property (
		CE_I && WR_I && ADDR_I == sscr_pkg::ADDR_STATUS && !WDATA_I[7] && !XFER_DONE_I |=> !done_ff
	) else $error("write of zero did not clear done flag");

	a_done_sticky: assert property (
		done_ff && !INT_VEC_ACK_I && !(WR_I && ADDR_I == sscr_pkg::ADDR_STATUS) |=> done_ff
	) else $error("done flag dropped without a clear");

	a_coll_set: assert property (
		CE_I && DATA_WR_I && SHIFT_BUSY_I |=> coll_ff
	) else $error("collision write did not set flag");

	a_coll_rewrite_clr: assert property (
		CE_I && DATA_WR_I && !SHIFT_BUSY_I |=> !coll_ff
	) else $error("idle data write did not clear collision flag");

	a_modf_set: assert property (
		CE_I && MASTER_I && !SELECT_PIN_DISABLE_O && !SS_N_I |=> modf_ff
	) else $error("low select in master mode did not set mode fault");

	a_modf_masked: assert property (
		CE_I && !MASTER_I && !modf_ff |=> !modf_ff
	) else $error("mode fault set outside master mode");

	a_modf_sw_clr: assert property (
		CE_I && WR_I && ADDR_I == sscr_pkg::ADDR_STATUS && !WDATA_I[5] && !(MASTER_I && !sel_dis_ff && !SS_N_I)
		|=> !modf_ff
	) else $error("write of zero did not clear mode fault");

	a_slave_release: assert property (
		CE_I && !MASTER_I |=> !SCK_OE_O && !SCK_O
	) else $error("serial clock driven while slave");

	a_read_once: assert property (
		CE_I && RD_I && ADDR_I == sscr_pkg::ADDR_STATUS ##1 CE_I && !RD_I |=> RDATA_O == 8'h00
	) else $error("read data held beyond one cycle");

	a_irq_follow: assert property (
		CE_I && (XFER_DONE_I && int_mask_ff[0] && !wr_int_mask) |=> IRQ_O
	) else $error("unmasked done event did not raise interrupt");

	a_coll_sw_clr: assert property (
		CE_I && wr_status && !WDATA_I[6] && !(DATA_WR_I && SHIFT_BUSY_I) |=> !coll_ff
	) else $error("write of zero did not clear collision flag");

	a_coll_sticky: assert property (
		coll_ff && !DATA_WR_I && !wr_status |=> coll_ff
	) else $error("collision flag dropped without a clear");

	a_coll_quiet: assert property (
		!coll_ff && !(DATA_WR_I && SHIFT_BUSY_I) |=> !coll_ff
	) else $error("collision flag set without a busy data write");

	a_done_quiet: assert property (
		!done_ff && !XFER_DONE_I |=> !done_ff
	) else $error("done flag set without a finished transfer");

	a_done_one_keeps: assert property (
		done_ff && wr_status && WDATA_I[7] && !INT_VEC_ACK_I |=> done_ff
	) else $error("write of one cleared done flag");

	a_modf_sticky: assert property (
		modf_ff && !wr_status |=> modf_ff
	) else $error("mode fault dropped without a clear");

	a_modf_quiet: assert property (
		!modf_ff && !(MASTER_I && !SELECT_PIN_DISABLE_O && !SS_N_I) |=> !modf_ff
	) else $error("mode fault set without a low select in master mode");

	////////////////////////////////////////////////////////////////////////////////
	// rate field, serial clock pin and shift tick
	a_rate_write: assert property (
		CE_I && wr_status |=> {6'h00, rate_ff} == ($past(WDATA_I) & 8'h03)
	) else $error("rate field did not take written value");

	a_rate_hold: assert property (
		!(CE_I && wr_status) |=> $stable(rate_ff)
	) else $error("rate field changed without a write");

	a_oe_master: assert property (
		CE_I && MASTER_I |=> SCK_OE_O
	) else $error("serial clock not driven as master");

	a_tick_master: assert property (
		CE_I && MASTER_I && $rose(SCK_O) |=> SHIFT_TICK_O
	) else $error("no shift tick after serial clock rise");

	a_tick_slave: assert property (
		CE_I && $past(CE_I) && !MASTER_I && $rose(PEER_SCK_I) |=> SHIFT_TICK_O
	) else $error("no shift tick after peer clock rise");

	////////////////////////////////////////////////////////////////////////////////
	// clock enable, interrupt and read port
	a_freeze_flags: assert property (
		!CE_I |=> $stable(done_ff) && $stable(coll_ff) && $stable(modf_ff)
	) else $error("flags changed while clock enable low");

	a_freeze_outputs: assert property (
		!CE_I |=> $stable(RDATA_O) && $stable(SCK_O) && $stable(IRQ_O)
	) else $error("outputs changed while clock enable low");

	a_irq_masked: assert property (
		CE_I && int_mask_ff == '0 && !wr_int_mask |=> !IRQ_O
	) else $error("interrupt raised with every event masked");

	a_unmapped_read: assert property (
		CE_I && RD_I && !rd_status && !rd_int_stat && !rd_int_mask |=> RDATA_O == 8'h00
	) else $error("unmapped read returned nonzero data");

	a_busy_view: assert property (
		CE_I && rd_status |=> RDATA_O[sscr_pkg::BIT_BUSY] == $past(SHIFT_BUSY_I)
	) else $error("busy bit not shown live in status");

endmodule // sscr_top

// ### rtl/sscr_pkg.sv
// package for the serial port status and clock-rate block
// assumes a byte-wide register port and one system clock
package sscr_pkg;

	////////////////////////////////////////////////////////////////////////////////
	// register map
	localparam logic [7:0] ADDR_STATUS = 8'hBD;
	localparam logic [7:0] ADDR_INT_STAT = 8'hBE;
	localparam logic [7:0] ADDR_INT_MASK = 8'hBF;

	// field positions of the status register
	localparam int BIT_DONE = 7;
	localparam int BIT_COLL = 6;
	localparam int BIT_MODF = 5;
	localparam int BIT_BUSY = 4;
	localparam int BIT_SEL_DIS = 3;
	localparam int BIT_LSBF = 2;

	// event bits of the interrupt status and mask registers
	localparam int EVT_DONE = 0;
	localparam int EVT_COLL = 1;
	localparam int EVT_MODF = 2;
	localparam int EVT_W = 3;

	////////////////////////////////////////////////////////////////////////////////
	// reset values
	localparam logic [1:0] RATE_RST = 2'h0;
	localparam logic [EVT_W-1:0] INT_MASK_RST = 3'h0;
	localparam logic [7:0] RDATA_RST = 8'h00;

	// divider counter width needed for divide by 16
	localparam int DIV_CNT_W = 3;

	////////////////////////////////////////////////////////////////////////////////
	// status register layout
	typedef struct packed {
		logic done;
		logic coll;
		logic modf;
		logic busy;
		logic sel_dis;
		logic lsbf;
		logic [1:0] rate;
	} sscr_status_type;

	// one register access from the port
	typedef struct packed {
		logic [7:0] addr;
		logic [7:0] wdata;
		logic wr;
		logic rd;
	} sscr_bus_type;

endpackage

// ### rtl/sscr_clk_div.sv
// serial clock divider: half period of 2**rate system clocks
// assumes rate is held steady by software while the divider is enabled
module sscr_clk_div #(
	parameter int CNT_W = sscr_pkg::DIV_CNT_W
) (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic ce_i,
	input wire logic en_i,
	input wire logic [1:0] rate_i,
	output logic sck_o,
	output logic rise_o
);

	if (CNT_W < sscr_pkg::DIV_CNT_W) begin : g_bad_width
		$error("sscr_clk_div: CNT_W too small for divide by 16");
	end

	logic [CNT_W-1:0] cnt_ff;
	logic sck_ff;
	logic rise_ff;

	////////////////////////////////////////////////////////////////////////////////
	// rate 00..11 gives divide by 2, 4, 8, 16
	wire [CNT_W-1:0] one_w = {{(CNT_W-1){1'b0}}, 1'b1};
	wire [CNT_W-1:0] half_m1 = (one_w << rate_i) - one_w;
	wire at_end = (cnt_ff == half_m1);
	wire toggle = en_i && at_end;
	wire [CNT_W-1:0] nxt_cnt = (!en_i || at_end) ? '0 : cnt_ff + one_w;
	// idle low when disabled so the first edge after enable is a full half period
	wire nxt_sck = en_i ? (sck_ff ^ toggle) : 1'b0;
	wire nxt_rise = toggle && !sck_ff;

	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			cnt_ff <= '0;
			sck_ff <= 1'b0;
			rise_ff <= 1'b0;
		end else if (ce_i) begin
			cnt_ff <= nxt_cnt;
			sck_ff <= nxt_sck;
			rise_ff <= nxt_rise;
		end
	end

	assign sck_o = sck_ff;
	assign rise_o = rise_ff;

	////////////////////////////////////////////////////////////////////////////////
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);

	a_div2_half: assert property (
		ce_i && en_i && rate_i == 2'b00 && $rose(sck_ff) |=> $fell(sck_ff)
	) else $error("divide by 2 high phase not one cycle");

	a_div16_half: assert property (
		(ce_i && en_i && rate_i == 2'b11 && $rose(sck_ff)) ##1 (ce_i && en_i && rate_i == 2'b11) [*7]
		|=> $fell(sck_ff)
	) else $error("divide by 16 high phase not eight cycles");

	a_div16_hold: assert property (
		(ce_i && en_i && rate_i == 2'b11 && $rose(sck_ff)) ##1 (ce_i && en_i && rate_i == 2'b11) [*6]
		|=> sck_ff
	) else $error("divide by 16 high phase ended early");

endmodule // sscr_clk_div

// ### verif/sscr_peer_model.sv
// external serial peer: drives the select pin and, when slave timing is wanted, a serial clock
// assumes the bench commands select and clock runs on the system clock
module sscr_peer_model (
	input wire logic clk_i,
	input wire logic select_i,
	input wire logic run_i,
	output logic ss_n_o,
	output logic sck_o
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [1:0] cnt_ff;
	// the select line has a pull-up, so a released pin reads high
	assign ss_n_o = select_i ? 1'b0 : 1'b1;
	// peer clock half period of three system clocks; stands low between frames
	always_ff @(posedge clk_i) begin
		if (!run_i) begin
			cnt_ff <= 2'h0;
			sck_o <= 1'b0;
		end else if (cnt_ff == 2'h2) begin
			cnt_ff <= 2'h0;
			sck_o <= ~sck_o;
		end else begin
			cnt_ff <= cnt_ff + 2'h1;
		end
	end
endmodule // sscr_peer_model

// ### verif/spi_status_clock_rate_test.sv
// self-checking bench for the serial status and clock-rate block
// assumes the register port answers reads one cycle later and never stalls
module spi_status_clock_rate_test;
	timeunit 1ns;
	timeprecision 1ns;
	logic CLK_I, RST_I, CE_I, WR_I, RD_I, SHIFT_BUSY_I, XFER_DONE_I, DATA_WR_I, INT_VEC_ACK_I, MASTER_I;
	logic [7:0] ADDR_I, WDATA_I, RDATA_O, rd_val;
	logic SS_N_I, PEER_SCK_I, SCK_O, SCK_OE_O, SHIFT_TICK_O, SELECT_PIN_DISABLE_O, LSB_FIRST_O, IRQ_O;
	logic peer_sel, peer_run;
	int fail_count = 0;
	int checked = 0;
	sscr_top i_sscr_top (.CLK_I(CLK_I), .RST_I(RST_I), .CE_I(CE_I), .ADDR_I(ADDR_I), .WDATA_I(WDATA_I),
		.WR_I(WR_I), .RD_I(RD_I), .RDATA_O(RDATA_O), .SHIFT_BUSY_I(SHIFT_BUSY_I), .XFER_DONE_I(XFER_DONE_I),
		.DATA_WR_I(DATA_WR_I), .INT_VEC_ACK_I(INT_VEC_ACK_I), .MASTER_I(MASTER_I), .SS_N_I(SS_N_I),
		.PEER_SCK_I(PEER_SCK_I), .SCK_O(SCK_O), .SCK_OE_O(SCK_OE_O), .SHIFT_TICK_O(SHIFT_TICK_O),
		.SELECT_PIN_DISABLE_O(SELECT_PIN_DISABLE_O), .LSB_FIRST_O(LSB_FIRST_O), .IRQ_O(IRQ_O));
	sscr_peer_model i_sscr_peer_model (.clk_i(CLK_I), .select_i(peer_sel), .run_i(peer_run),
		.ss_n_o(SS_N_I), .sck_o(PEER_SCK_I));
	////////////////////////////////////////////////////////////////////////////////
	initial begin
		CLK_I = 1'b0;
		forever #50 CLK_I = ~CLK_I;
	end
	task final_report;
		$display("comparisons %0d, mismatches %0d", checked, fail_count);
		if (fail_count == 0 && checked > 0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	endtask
	task chk(input logic [7:0] got, input logic [7:0] exp);
		checked++;
		if (got !== exp) begin
			fail_count++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge CLK_I);
		ADDR_I <= a;
		WDATA_I <= d;
		WR_I <= 1'b1;
		@(posedge CLK_I);
		WR_I <= 1'b0;
	endtask
	// read data stand only in the cycle after the strobe
	task rd(input logic [7:0] a);
		@(posedge CLK_I);
		ADDR_I <= a;
		RD_I <= 1'b1;
		@(posedge CLK_I);
		RD_I <= 1'b0;
		#1 rd_val = RDATA_O;
	endtask
	task pulse(input int k);
		@(posedge CLK_I);
		case (k)
			0: XFER_DONE_I <= 1'b1;
			1: DATA_WR_I <= 1'b1;
			default: INT_VEC_ACK_I <= 1'b1;
		endcase
		@(posedge CLK_I);
		XFER_DONE_I <= 1'b0;
		DATA_WR_I <= 1'b0;
		INT_VEC_ACK_I <= 1'b0;
	endtask
	////////////////////////////////////////////////////////////////////////////////
	task rate_case(input int r);
		int n, ticks;
		logic prev;
		wr(sscr_pkg::ADDR_STATUS, {6'h00, r[1:0]});
		rd(sscr_pkg::ADDR_STATUS);
		chk(rd_val, {6'h00, r[1:0]});
		@(posedge CLK_I);
		MASTER_I <= 1'b1;
		prev = 1'b1;
		n = 0;
		// skip the first two rises: a fresh start may shorten the first period
		for (int i = 0; i < 100 && n < 2; i++) begin
			@(posedge CLK_I);
			#1 if (SCK_O === 1'b1 && prev === 1'b0) n++;
			prev = SCK_O;
		end
		n = 0;
		ticks = 0;
		prev = 1'b1;
		for (int i = 0; i < 100; i++) begin
			@(posedge CLK_I);
			#1 n++;
			if (SHIFT_TICK_O === 1'b1) ticks++;
			if (SCK_O === 1'b1 && prev === 1'b0) break;
			prev = SCK_O;
		end
		chk(8'(n), 8'(2 << r));
		chk(8'(ticks), 8'h01);
		chk({7'h00, SCK_OE_O}, 8'h01);
		@(posedge CLK_I);
		MASTER_I <= 1'b0;
		repeat (4) @(posedge CLK_I);
		#1 chk({6'h00, SCK_O, SCK_OE_O}, 8'h00);
		wr(sscr_pkg::ADDR_STATUS, 8'h00);
	endtask
	task slave_tick;
		int rises, ticks;
		logic prev;
		rises = 0;
		ticks = 0;
		prev = 1'b0;
		@(posedge CLK_I);
		peer_run <= 1'b1;
		repeat (60) begin
			@(posedge CLK_I);
			#1 if (PEER_SCK_I && !prev) rises++;
			prev = PEER_SCK_I;
			if (SHIFT_TICK_O === 1'b1) ticks++;
			if (SCK_OE_O !== 1'b0) ticks = 99;
		end
		peer_run <= 1'b0;
		repeat (3) begin
			@(posedge CLK_I);
			#1 if (SHIFT_TICK_O === 1'b1) ticks++;
		end
		chk(8'(ticks), 8'(rises));
	endtask
	task done_case;
		pulse(0);
		rd(sscr_pkg::ADDR_STATUS);
		chk(rd_val, 8'h80);
		wr(sscr_pkg::ADDR_STATUS, 8'hE0);
		rd(sscr_pkg::ADDR_STATUS);
		chk(rd_val, 8'h80);
		wr(sscr_pkg::ADDR_STATUS, 8'h00);
		rd(sscr_pkg::ADDR_STATUS);
		chk(rd_val, 8'h00);
		pulse(0);
		pulse(2);
		rd(sscr_pkg::ADDR_STATUS);
		chk(rd_val, 8'h00);
	endtask
	task coll_case;
		SHIFT_BUSY_I <= 1'b1;
		pulse(1);
		rd(sscr_pkg::ADDR_STATUS);
		chk(rd_val, 8'h50);
		SHIFT_BUSY_I <= 1'b0;
		pulse(1);
		rd(sscr_pkg::ADDR_STATUS);
		chk(rd_val, 8'h00);
		SHIFT_BUSY_I <= 1'b1;
		pulse(1);
		SHIFT_BUSY_I <= 1'b0;
		wr(sscr_pkg::ADDR_STATUS, 8'hE0);
		rd(sscr_pkg::ADDR_STATUS);
		chk(rd_val, 8'h40);
		wr(sscr_pkg::ADDR_STATUS, 8'h00);
		rd(sscr_pkg::ADDR_STATUS);
		chk(rd_val, 8'h00);
	endtask
	task modf_case;
		MASTER_I <= 1'b1;
		peer_sel <= 1'b1;
		repeat (3) @(posedge CLK_I);
		rd(sscr_pkg::ADDR_STATUS);
		chk(rd_val, 8'h20);
		peer_sel <= 1'b0;
		wr(sscr_pkg::ADDR_STATUS, 8'h0C);
		peer_sel <= 1'b1;
		repeat (3) @(posedge CLK_I);
		rd(sscr_pkg::ADDR_STATUS);
		chk(rd_val, 8'h0C);
		chk({6'h00, SELECT_PIN_DISABLE_O, LSB_FIRST_O}, 8'h03);
		peer_sel <= 1'b0;
		MASTER_I <= 1'b0;
		wr(sscr_pkg::ADDR_STATUS, 8'h00);
	endtask
	task irq_case;
		wr(sscr_pkg::ADDR_INT_STAT, 8'h07);
		wr(sscr_pkg::ADDR_INT_MASK, 8'h01);
		pulse(0);
		repeat (2) @(posedge CLK_I);
		#1 chk({7'h00, IRQ_O}, 8'h01);
		rd(sscr_pkg::ADDR_INT_STAT);
		chk(rd_val, 8'h01);
		wr(sscr_pkg::ADDR_INT_STAT, 8'h01);
		#1 chk({7'h00, IRQ_O}, 8'h00);
		wr(sscr_pkg::ADDR_INT_MASK, 8'h00);
		pulse(0);
		repeat (2) @(posedge CLK_I);
		#1 chk({7'h00, IRQ_O}, 8'h00);
		rd(8'h10);
		chk(rd_val, 8'h00);
	endtask
	// clock enable low must freeze the done flag; a mid-run reset must restore every status field
	task freeze_case;
		wr(sscr_pkg::ADDR_STATUS, 8'h00);
		@(posedge CLK_I);
		CE_I <= 1'b0;
		pulse(0);
		@(posedge CLK_I);
		CE_I <= 1'b1;
		rd(sscr_pkg::ADDR_STATUS);
		chk(rd_val, 8'h00);
		wr(sscr_pkg::ADDR_STATUS, 8'h0F);
		@(posedge CLK_I);
		RST_I <= 1'b1;
		repeat (2) @(posedge CLK_I);
		RST_I <= 1'b0;
		#1 chk({5'h00, SCK_OE_O, SELECT_PIN_DISABLE_O, LSB_FIRST_O}, 8'h00);
		rd(sscr_pkg::ADDR_STATUS);
		chk(rd_val, 8'h00);
	endtask
	////////////////////////////////////////////////////////////////////////////////
	initial begin
		{RST_I, CE_I} = 2'b11;
		{WR_I, RD_I, SHIFT_BUSY_I, XFER_DONE_I, DATA_WR_I, INT_VEC_ACK_I, MASTER_I} = 7'h00;
		{ADDR_I, WDATA_I} = 16'h0000;
		{peer_sel, peer_run} = 2'b00;
		repeat (16) @(posedge CLK_I);
		RST_I <= 1'b0;
		rd(sscr_pkg::ADDR_STATUS);
		chk(rd_val, 8'h00);
		for (int r = 0; r < 4; r++) rate_case(r);
		slave_tick();
		done_case();
		coll_case();
		modf_case();
		irq_case();
		freeze_case();
		final_report();
	end
	initial begin
		#3000000;
		fail_count++;
		final_report();
	end
endmodule // spi_status_clock_rate_test
